// *** logic/asc_acq.sv ***
// What this block does
// R1: external multiphase gives every section its own sample expression plus the master.
// R2: a true section expression loads that section's inputs, replacing the old value.
// R3: a true master expression passes all three section values together to trace control.
// R4: with clock delay active, each master sample adds exactly one to the level counter.
// R5: section expressions share the master's form and the same six clock inputs.
// R6: mixed single-phase: each section uses the master expression or the internal period.
// R7: mixed single-phase with all sections external behaves as external single-phase.
// R8: all sections internal sample every input, master still chooses what goes on.
// R9: mixed multiphase always presents samples using the external master expression.
// R10: mixed multiphase external sections use their own expression, same or different.
// R11: mixed multiphase internal sections sample at the configured internal period.
// R12: internal extended runs the master from the internal period, 20 ns to 160 ms.
// R13: internal extended sections sample at the master period or every 10 ns.
// R14: trace control gets at most one sample per 20 ns.
// R15: expression is true when all and-terms or any or-term fire.
// R16: terms are edge sensitive: rising, falling or excluded.
// R17: period accepts only one-to-sixteen multiples of a decade unit, others rejected.
// R18: each section register holds sixteen inputs and clears to zero at reset.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
module asc_acq
    import asc_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sample_clk,
    input wire logic [PROBE_W-1:0] probe_in,
    input wire logic [NUM_CLK-1:0] ext_clock_in,
    input wire logic trace_delay_active,
    input wire logic trace_level_change,
    output logic sample_valid,
    output logic [PROBE_W-1:0] sample_data,
    output logic [CNT_W-1:0] sample_count
);

    localparam asc_cfg_s CFG_RESET = '{
        mode: MODE_INTERNAL,
        period_cyc: asc_period_cycles(RST_MULT, RST_EXP),
        master_expr: '0,
        sect_expr: '0,
        sect_sel: '0
    };

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_full;
        logic w_full;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [4:0] period_mult;
        logic [2:0] period_exp;
        asc_cfg_s cfg;
        asc_cfg_s shadow;
        logic illegal;
        logic dirty;
        logic busy;
        logic req;
        logic ack_s1;
        logic ack_s2;
    } asc_bus_s;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic ack;
        asc_cfg_s cfg;
        logic [NUM_CLK-1:0] clk_s1;
        logic [NUM_CLK-1:0] clk_s2;
        logic [NUM_CLK-1:0] clk_d;
        logic [PROBE_W-1:0] probe_s1;
        logic [PROBE_W-1:0] probe_s2;
        logic [PERIOD_W-1:0] tick_cnt;
        logic [1:0] gap;
        logic [NUM_SECT-1:0][SECT_W-1:0] sect_reg;
        logic valid;
        logic [PROBE_W-1:0] data;
        logic [CNT_W-1:0] count;
    } asc_link_s;

    localparam logic [1:0] GAP_FULL = 2'(TRACE_MIN_CYC);

    asc_bus_s b;
    asc_bus_s next_b;
    asc_link_s l;
    asc_link_s next_l;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] asc_merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction : asc_merge

    // register bus side: axi4-lite slave, configuration and handshake to the link
    always_comb
    begin
        logic [31:0] old_word;
        logic [31:0] mw;
        logic [4:0] wm;
        logic [2:0] we;
        logic [PERIOD_W-1:0] wcyc;
        logic hit;
        logic set_illegal;
        next_b = b;
        old_word = 32'h00000000;
        mw = 32'h00000000;
        wm = 5'h00;
        we = 3'h0;
        wcyc = '0;
        hit = 1'b1;
        set_illegal = 1'b0;
        next_b.ack_s1 = l.ack;
        next_b.ack_s2 = b.ack_s1;

        if (s_axi_awvalid && b.awready)
        begin
            next_b.awaddr = s_axi_awaddr;
            next_b.aw_full = 1'b1;
            next_b.awready = 1'b0;
        end
        if (s_axi_wvalid && b.wready)
        begin
            next_b.wdata = s_axi_wdata;
            next_b.wstrb = s_axi_wstrb;
            next_b.w_full = 1'b1;
            next_b.wready = 1'b0;
        end

        // register write once address and data are both held
        if (b.aw_full && b.w_full && !b.bvalid)
        begin
            unique case (b.awaddr)
                REG_MODE: old_word = {29'h0, b.cfg.mode};
                REG_PERIOD: old_word = {21'h0, b.period_exp, 3'h0, b.period_mult};
                REG_MASTER_EXPR: old_word = {20'h0, b.cfg.master_expr};
                REG_EXPR_A: old_word = {20'h0, b.cfg.sect_expr[0]};
                REG_EXPR_B: old_word = {20'h0, b.cfg.sect_expr[1]};
                REG_EXPR_C: old_word = {20'h0, b.cfg.sect_expr[2]};
                REG_SECT_SEL: old_word = {29'h0, b.cfg.sect_sel};
                REG_STATUS: old_word = 32'h00000000;
                default: hit = 1'b0;
            endcase
            mw = asc_merge(old_word, b.wdata, b.wstrb);
            wm = mw[PER_MULT_LSB +: PER_MULT_W];
            we = mw[PER_EXP_LSB +: PER_EXP_W];
            wcyc = asc_period_cycles(wm, we);
            unique case (b.awaddr)
                REG_MODE: next_b.cfg.mode = mw[2:0];
                REG_PERIOD:
                begin
                    // only 1..16 times a decade unit, never below 20 ns
                    if (wm >= PER_MULT_MIN && wm <= PER_MULT_MAX && we <= PER_EXP_MAX
                        && wcyc >= MIN_PERIOD_CYC) // R17 R12
                    begin
                        next_b.period_mult = wm;
                        next_b.period_exp = we;
                        next_b.cfg.period_cyc = wcyc;
                    end
                    else
                    begin
                        set_illegal = 1'b1; // R17
                    end
                end
                REG_MASTER_EXPR: next_b.cfg.master_expr = mw[EXPR_W-1:0];
                REG_EXPR_A: next_b.cfg.sect_expr[0] = mw[EXPR_W-1:0]; // R1
                REG_EXPR_B: next_b.cfg.sect_expr[1] = mw[EXPR_W-1:0]; // R1
                REG_EXPR_C: next_b.cfg.sect_expr[2] = mw[EXPR_W-1:0]; // R1
                REG_SECT_SEL: next_b.cfg.sect_sel = mw[NUM_SECT-1:0];
                REG_STATUS:
                begin
                    if (b.wstrb[0] && b.wdata[ST_ILLEGAL])
                    begin
                        next_b.illegal = 1'b0;
                    end
                end
                default: next_b.dirty = b.dirty;
            endcase
            if (hit && b.awaddr != REG_STATUS)
            begin
                next_b.dirty = 1'b1;
            end
            next_b.bvalid = 1'b1;
            next_b.bresp = hit ? RESP_OKAY : RESP_SLVERR;
            next_b.aw_full = 1'b0;
            next_b.w_full = 1'b0;
        end
        // a rejected period in the clearing cycle still sets the flag
        if (set_illegal)
        begin
            next_b.illegal = 1'b1;
        end
        if (b.bvalid && s_axi_bready)
        begin
            next_b.bvalid = 1'b0;
            next_b.awready = 1'b1;
            next_b.wready = 1'b1;
        end

        // register read
        if (s_axi_arvalid && b.arready)
        begin
            next_b.arready = 1'b0;
            next_b.rvalid = 1'b1;
            next_b.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                REG_MODE: next_b.rdata = {29'h0, b.cfg.mode};
                REG_PERIOD: next_b.rdata = {21'h0, b.period_exp, 3'h0, b.period_mult};
                REG_MASTER_EXPR: next_b.rdata = {20'h0, b.cfg.master_expr};
                REG_EXPR_A: next_b.rdata = {20'h0, b.cfg.sect_expr[0]};
                REG_EXPR_B: next_b.rdata = {20'h0, b.cfg.sect_expr[1]};
                REG_EXPR_C: next_b.rdata = {20'h0, b.cfg.sect_expr[2]};
                REG_SECT_SEL: next_b.rdata = {29'h0, b.cfg.sect_sel};
                REG_STATUS: next_b.rdata = {30'h0, b.busy | b.dirty, b.illegal};
                REG_PERIOD_CYC: next_b.rdata = {8'h00, b.cfg.period_cyc};
                default:
                begin
                    next_b.rdata = 32'h00000000;
                    next_b.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (b.rvalid && s_axi_rready)
        begin
            next_b.rvalid = 1'b0;
            next_b.arready = 1'b1;
        end

        // shadow stays frozen while the link side may be copying it
        if (b.busy && b.ack_s2 == b.req)
        begin
            next_b.busy = 1'b0;
        end
        if (!b.busy && b.dirty)
        begin
            next_b.shadow = b.cfg;
            next_b.req = ~b.req;
            next_b.busy = 1'b1;
            next_b.dirty = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            b <= '0;
            b.awready <= 1'b1;
            b.wready <= 1'b1;
            b.arready <= 1'b1;
            b.period_mult <= RST_MULT;
            b.period_exp <= RST_EXP;
            b.cfg <= CFG_RESET;
            b.shadow <= CFG_RESET;
        end
        else
        begin
            b <= next_b;
        end
    end

    // link side: probe capture, clock expressions, section registers, master sample
    always_comb
    begin
        logic [NUM_CLK-1:0] rise;
        logic [NUM_CLK-1:0] fall;
        logic master_expr;
        logic tick;
        logic master;
        logic ext_master;
        logic [NUM_SECT-1:0] strobe;
        logic [NUM_SECT-1:0] own_expr;
        logic [PROBE_W-1:0] out_data;
        next_l = l;
        next_l.rst_s1 = aresetn;
        next_l.rst_s2 = l.rst_s1;
        next_l.req_s1 = b.req;
        next_l.req_s2 = l.req_s1;
        next_l.clk_s1 = ext_clock_in;
        next_l.clk_s2 = l.clk_s1;
        next_l.clk_d = l.clk_s2;
        next_l.probe_s1 = probe_in;
        next_l.probe_s2 = l.probe_s1;

        // edge sensitive terms from the synchronised clock inputs
        rise = l.clk_s2 & ~l.clk_d; // R16
        fall = ~l.clk_s2 & l.clk_d; // R16
        master_expr = asc_expr_eval(l.cfg.master_expr, rise, fall); // R15
        for (int s = 0; s < NUM_SECT; s++)
        begin
            own_expr[s] = asc_expr_eval(l.cfg.sect_expr[s], rise, fall); // R5
        end

        // internal period timebase, one tick per configured period
        tick = (l.tick_cnt == '0);
        next_l.tick_cnt = tick ? l.cfg.period_cyc - 24'h000001 : l.tick_cnt - 24'h000001;

        ext_master = (l.cfg.mode != MODE_INTERNAL) && (l.cfg.mode != MODE_INT_EXTENDED);
        // internal modes time the master, all others use the expression
        master = ext_master ? master_expr : tick; // R9 R12
        // trace control never sees two samples closer than the minimum
        if (l.gap < GAP_FULL)
        begin
            master = 1'b0; // R14
        end

        // per-section sample strobes by mode
        for (int s = 0; s < NUM_SECT; s++)
        begin
            unique case (l.cfg.mode)
                MODE_EXT_MULTI: strobe[s] = own_expr[s]; // R1 R2
                MODE_MIXED_SINGLE: strobe[s] = l.cfg.sect_sel[s] ? tick : master; // R6 R7 R8
                MODE_MIXED_MULTI: strobe[s] = l.cfg.sect_sel[s] ? tick : own_expr[s]; // R10 R11
                MODE_INT_EXTENDED: strobe[s] = l.cfg.sect_sel[s] ? 1'b1 : master; // R13
                default: strobe[s] = master;
            endcase
        end

        // a section clocked in the master's own cycle hands on its fresh inputs
        for (int s = 0; s < NUM_SECT; s++)
        begin
            if (strobe[s])
            begin
                next_l.sect_reg[s] = l.probe_s2[SECT_W*s +: SECT_W]; // R2
            end
            out_data[SECT_W*s +: SECT_W] = strobe[s] ? l.probe_s2[SECT_W*s +: SECT_W]
                : l.sect_reg[s];
        end

        next_l.valid = master; // R3
        if (master)
        begin
            next_l.data = out_data; // R3
            next_l.gap = 2'h1;
        end
        else if (l.gap < GAP_FULL)
        begin
            next_l.gap = l.gap + 2'h1;
        end

        // level sample count; a level change starts a fresh count
        if (trace_level_change)
        begin
            next_l.count = '0;
        end
        if (master && trace_delay_active)
        begin
            next_l.count = (trace_level_change ? '0 : l.count) + CNT_W'(1); // R4
        end

        // new configuration restarts the timebase
        next_l.ack = l.req_s2;
        if (l.req_s2 != l.ack)
        begin
            next_l.cfg = b.shadow;
            next_l.tick_cnt = '0;
        end
    end

    always_ff @(posedge sample_clk)
    begin
        if (!l.rst_s2)
        begin
            l <= '0;
            l.rst_s1 <= next_l.rst_s1;
            l.rst_s2 <= next_l.rst_s2;
            l.cfg <= CFG_RESET;
            l.gap <= GAP_FULL;
            l.sect_reg <= '0; // R18
        end
        else
        begin
            l <= next_l;
        end
    end

    assign s_axi_awready = b.awready;
    assign s_axi_wready = b.wready;
    assign s_axi_bvalid = b.bvalid;
    assign s_axi_bresp = b.bresp;
    assign s_axi_arready = b.arready;
    assign s_axi_rvalid = b.rvalid;
    assign s_axi_rdata = b.rdata;
    assign s_axi_rresp = b.rresp;
    assign sample_valid = l.valid;
    assign sample_data = l.data;
    assign sample_count = l.count;

endmodule : asc_acq

// *** include/asc_pkg.sv ***
package asc_pkg;

    // widths
    localparam int NUM_SECT = 3;
    localparam int SECT_W = 16;
    localparam int PROBE_W = 48;
    localparam int NUM_CLK = 6;
    localparam int EXPR_W = 12;
    localparam int PERIOD_W = 24;
    localparam int AXI_ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_PERIOD = 8'h04;
    localparam logic [7:0] REG_MASTER_EXPR = 8'h08;
    localparam logic [7:0] REG_EXPR_A = 8'h0c;
    localparam logic [7:0] REG_EXPR_B = 8'h10;
    localparam logic [7:0] REG_EXPR_C = 8'h14;
    localparam logic [7:0] REG_SECT_SEL = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_PERIOD_CYC = 8'h20;

    // acquisition modes
    localparam logic [2:0] MODE_INTERNAL = 3'h0;
    localparam logic [2:0] MODE_EXT_SINGLE = 3'h1;
    localparam logic [2:0] MODE_EXT_MULTI = 3'h2;
    localparam logic [2:0] MODE_MIXED_SINGLE = 3'h3;
    localparam logic [2:0] MODE_MIXED_MULTI = 3'h4;
    localparam logic [2:0] MODE_INT_EXTENDED = 3'h5;

    // clock term codes, two bits per term
    localparam logic [1:0] TERM_OFF = 2'h0;
    localparam logic [1:0] TERM_RISE = 2'h1;
    localparam logic [1:0] TERM_FALL = 2'h2;
    // terms 0..2: and_clock_low/mid/top, terms 3..5: or_clock_low/mid/top
    localparam int AND_TERMS = 3;

    // period register fields
    localparam int PER_MULT_LSB = 0;
    localparam int PER_MULT_W = 5;
    localparam int PER_EXP_LSB = 8;
    localparam int PER_EXP_W = 3;
    localparam logic [4:0] PER_MULT_MIN = 5'h01;
    localparam logic [4:0] PER_MULT_MAX = 5'h10;
    localparam logic [2:0] PER_EXP_MAX = 3'h6;

    // timing: one link clock cycle is the fastest sample interval
    localparam int FAST_NS = 10;
    localparam int TRACE_MIN_NS = 20;
    localparam int MIN_PERIOD_NS = 20;
    localparam int TRACE_MIN_CYC = (TRACE_MIN_NS + FAST_NS - 1) / FAST_NS;
    localparam logic [23:0] MIN_PERIOD_CYC = 24'((MIN_PERIOD_NS + FAST_NS - 1) / FAST_NS);

    // status bits
    localparam int ST_ILLEGAL = 0;
    localparam int ST_PENDING = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // reset configuration: internal mode, 1 x 10^1 fast cycles
    localparam logic [4:0] RST_MULT = 5'h01;
    localparam logic [2:0] RST_EXP = 3'h1;

    typedef struct packed {
        logic [2:0] mode;
        logic [PERIOD_W-1:0] period_cyc;
        logic [EXPR_W-1:0] master_expr;
        logic [NUM_SECT-1:0][EXPR_W-1:0] sect_expr;
        logic [NUM_SECT-1:0] sect_sel;
    } asc_cfg_s;

    // and-group true when at least one and term is selected and every selected one fired, or-group on any
    function automatic logic asc_expr_eval(
        input logic [EXPR_W-1:0] e,
        input logic [NUM_CLK-1:0] rise,
        input logic [NUM_CLK-1:0] fall
    );
        logic and_ok;
        logic and_any;
        logic or_hit;
        logic hit;
        and_ok = 1'b1;
        and_any = 1'b0;
        or_hit = 1'b0;
        for (int i = 0; i < NUM_CLK; i++)
        begin
            hit = (e[2*i +: 2] == TERM_RISE && rise[i])
                || (e[2*i +: 2] == TERM_FALL && fall[i]);
            if (i < AND_TERMS)
            begin
                if (e[2*i +: 2] != TERM_OFF)
                begin
                    and_any = 1'b1;
                    and_ok = and_ok & hit;
                end
            end
            else
            begin
                or_hit = or_hit | hit;
            end
        end
        return (and_any & and_ok) | or_hit;
    endfunction : asc_expr_eval

    function automatic logic [PERIOD_W-1:0] asc_period_cycles(
        input logic [4:0] mult,
        input logic [2:0] exp10
    );
        logic [PERIOD_W-1:0] scale;
        unique case (exp10)
            3'h0: scale = 24'h000001;
            3'h1: scale = 24'h00000a;
            3'h2: scale = 24'h000064;
            3'h3: scale = 24'h0003e8;
            3'h4: scale = 24'h002710;
            3'h5: scale = 24'h0186a0;
            3'h6: scale = 24'h0f4240;
            default: scale = 24'h000000;
        endcase
        return 24'(scale * {19'h00000, mult});
    endfunction : asc_period_cycles

endpackage : asc_pkg

// *** verification/asc_acq_chk.sv ***
module asc_acq_chk
    import asc_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sample_clk,
    input wire logic sample_valid,
    input wire logic [PROBE_W-1:0] sample_data,
    input wire logic [CNT_W-1:0] sample_count
);
    // both halves of a write taken on one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // write answer two cycles after the take, read answer one
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wr_both |=> ##1 s_axi_bvalid) else $error("no bvalid");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rd_take |=> s_axi_rvalid) else $error("no rvalid");
    a_resp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    a_rdata_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
    a_read_single: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready) else $error("second read accepted");
    // minimum sample spacing
    a_sample_pulse: assert property (@(posedge sample_clk) disable iff (!aresetn)
        sample_valid |=> !sample_valid) else $error("samples too close");
    a_data_held: assert property (@(posedge sample_clk) disable iff (!aresetn)
        !sample_valid |-> $stable(sample_data)) else $error("data moved");
    a_count_step: assert property (@(posedge sample_clk) disable iff (!aresetn)
        sample_count > $past(sample_count)
        |-> sample_valid && sample_count == $past(sample_count) + 1)
        else $error("count step wrong");
endmodule : asc_acq_chk

bind asc_acq asc_acq_chk #(.CNT_W(CNT_W)) chk_i (.*);

// *** verification/asc_sut.sv ***
module asc_sut
    import asc_pkg::*;
(
    input wire logic sample_clk,
    input wire logic [NUM_CLK-1:0] clk_req,
    input wire logic [PROBE_W-1:0] data_req,
    output logic [NUM_CLK-1:0] ext_clock_in = '0,
    output logic [PROBE_W-1:0] probe_in = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    // system under test launches its lines just after its own clock edge
    always @(posedge sample_clk)
    begin
        probe_in <= data_req;
        ext_clock_in <= clk_req;
    end
endmodule : asc_sut

// *** verification/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import asc_pkg::*;
    logic aclk = 0, sample_clk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, sample_count;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, sample_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [PROBE_W-1:0] probe_in, sample_data, data_req = '0, keep;
    logic [NUM_CLK-1:0] ext_clock_in, clk_req = '0;
    logic trace_delay_active = 0, trace_level_change = 0;
    int err_count = 0, samples_checked = 0, n_smp = 0, n0, c0;
    // illegal periods: mult 17, mult 0, exponent 7, one cycle
    logic [31:0] bad_per [4] = '{32'h011, 32'h000, 32'h701, 32'h001};
    // expression table: master, clocks before, clocks after, samples due
    logic [11:0] t_ex [7] = '{12'h015, 12'h015, 12'h002, 12'h002, 12'h400, 12'h200, 12'h000};
    logic [5:0] t_a [7] = '{6'h00, 6'h00, 6'h01, 6'h00, 6'h00, 6'h10, 6'h00};
    logic [5:0] t_b [7] = '{6'h07, 6'h03, 6'h00, 6'h01, 6'h20, 6'h00, 6'h3f};
    int t_n [7] = '{1, 0, 1, 0, 1, 1, 0};

    always #25 aclk = ~aclk;
    always #24 sample_clk = ~sample_clk;

    asc_acq #(.CNT_W(32)) asc_acq_i (.*);
    asc_sut asc_sut_i (.*);

    // count master samples handed to trace control
    always @(posedge sample_clk)
        if (sample_valid === 1'b1)
            n_smp++;

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask : rdr

    // write then wait until the link side has taken the new setup
    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        do
            rdr(REG_STATUS);
        while (rd[ST_PENDING] !== 1'b0);
    endtask : cfg

    // probe data settles before the clock lines move
    task automatic pulse(input logic [5:0] c, input logic [47:0] d);
        @(posedge sample_clk);
        data_req <= d;
        repeat (3) @(posedge sample_clk);
        clk_req <= c;
        repeat (10) @(posedge sample_clk);
    endtask : pulse

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    initial
    begin
        #2ms;
        err_count++;
        conclude;
    end

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        trace_delay_active <= 1'b1;
        @(posedge aclk);
        // reset values and an unmapped place
        check(sample_data, '0);
        rdr(REG_MODE);
        check(rd, MODE_INTERNAL);
        rdr(REG_PERIOD);
        check(rd, 32'h101);
        rdr(REG_PERIOD_CYC);
        check(rd, 32'd10);
        rdr(8'h40);
        check({rs, rd}, {RESP_SLVERR, 32'h0});
        $display("test registers done");
        // rejected periods leave the old one and flag it
        foreach (bad_per[i])
        begin
            wr(REG_PERIOD, bad_per[i]);
            rdr(REG_PERIOD);
            check(rd, 32'h101);
            rdr(REG_STATUS);
            check(rd[ST_ILLEGAL], 1'b1);
            wr(REG_STATUS, 32'h1);
        end
        cfg(REG_PERIOD, 32'h610);
        rdr(REG_PERIOD_CYC);
        check(rd, 32'hf42400);
        cfg(REG_PERIOD, 32'h004);
        $display("test period done");
        // master tick rate holds even with fast sections
        for (int m = 0; m < 2; m++)
        begin
            cfg(REG_SECT_SEL, 32'h7);
            cfg(REG_MODE, m ? MODE_INT_EXTENDED : MODE_INTERNAL);
            n0 = n_smp;
            repeat (80) @(posedge sample_clk);
            check(((n_smp - n0) >= 19) && ((n_smp - n0) <= 21), 1'b1);
        end
        $display("test internal done");
        // expression table under external single and mixed single all external
        cfg(REG_SECT_SEL, 32'h0);
        for (int m = 0; m < 2; m++)
        begin
            cfg(REG_MODE, m ? MODE_MIXED_SINGLE : MODE_EXT_SINGLE);
            foreach (t_ex[i])
            begin
                cfg(REG_MASTER_EXPR, {20'h0, t_ex[i]});
                pulse(t_a[i], '0);
                n0 = n_smp;
                c0 = sample_count;
                pulse(t_b[i], {16'(i + 1), 16'h5a00, 16'(m)});
                check(n_smp - n0, t_n[i]);
                check(sample_count - c0, t_n[i]);
                if (t_n[i] == 1)
                    check(sample_data, {16'(i + 1), 16'h5a00, 16'(m)});
            end
        end
        $display("test expressions done");
        // section A on its own clock, master on or_clock_top
        for (int m = 0; m < 2; m++)
        begin
            cfg(REG_MODE, m ? MODE_MIXED_MULTI : MODE_EXT_MULTI);
            cfg(REG_MASTER_EXPR, 32'h400);
            cfg(REG_EXPR_A, 32'h100);
            cfg(REG_EXPR_B, 32'h0);
            cfg(REG_EXPR_C, 32'h0);
            keep = sample_data;
            pulse(6'h00, 48'h0);
            pulse(6'h10, 48'h1111_2222_a001);
            pulse(6'h00, 48'h0);
            pulse(6'h10, 48'h3333_4444_b00c);
            trace_delay_active <= m[0];
            c0 = sample_count;
            pulse(6'h30, 48'h5555_6666_7777);
            check(sample_data[15:0], 16'hb00c);
            check(sample_data[47:16], keep[47:16]);
            check(sample_count - c0, m);
            pulse(6'h00, 48'h0);
        end
        $display("test multiphase done");
        conclude;
    end
endmodule : tb_top
